// *** rtl/comparator_channel.sv ***
// One comparator output path: synchroniser, noise filter, polarity, gate, edge detect
`timescale 1ns/1ps
`include "comparator_control_defines.svh"
module comparator_channel (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       raw_result,
    input  wire logic       enable,
    input  wire logic [1:0] filter_code,
    input  wire logic       invert,
    input  wire logic       gate,
    input  wire logic       rise_en,
    input  wire logic       fall_en,
    output logic            cmp_out,
    output logic            irq
);
    logic [2:0] sync_q;
    logic       samp_q;
    logic       filt_q;
    logic [4:0] cnt_q;
    logic [4:0] limit;
    logic       out_q;
    logic       prev_q;
    logic       irq_q;

    // ------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_q <= 3'h0;
        end else begin
            sync_q <= {sync_q[1:0], raw_result};
        end
    end

    // A level counts only once two stages agree
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            samp_q <= 1'b0;
        end else if (sync_q[1] == sync_q[2]) begin
            samp_q <= sync_q[2];
        end
    end

    // ------------------------------------------------------------
    // Noise filter
    // ------------------------------------------------------------
    always_comb begin
        unique case (comparator_control_pkg::filter_width_e'(filter_code))
            comparator_control_pkg::FILT_W2:  limit = {1'b0, `CMP_FILT_LIM_01};
            comparator_control_pkg::FILT_W4:  limit = {1'b0, `CMP_FILT_LIM_10};
            comparator_control_pkg::FILT_W16: limit = `CMP_FILT_LIM_11;
            comparator_control_pkg::FILT_OFF: limit = 5'h01;
        endcase
    end

    // Sampling the level adds up to one clock of extra rejection
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            filt_q <= 1'b0;
            cnt_q  <= 5'h00;
        end else if (!enable) begin
            filt_q <= 1'b0;
            cnt_q  <= 5'h00;
        end else if (filter_code == comparator_control_pkg::FILT_OFF) begin
            filt_q <= samp_q;
            cnt_q  <= 5'h00;
        end else if (samp_q == filt_q) begin
            cnt_q  <= 5'h00;
        end else if (cnt_q == limit - 5'h01) begin
            filt_q <= samp_q;
            cnt_q  <= 5'h00;
        end else begin
            cnt_q  <= cnt_q + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // Polarity, gate and edge detect
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= 1'b0;
        end else begin
            out_q <= gate & enable & (filt_q ^ invert);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q <= 1'b0;
            irq_q  <= 1'b0;
        end else begin
            prev_q <= out_q;
            irq_q  <= (rise_en & out_q & ~prev_q) | (fall_en & ~out_q & prev_q);
        end
    end

    assign cmp_out = out_q;
    assign irq     = irq_q;

    gate_low_out_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !gate |=> !cmp_out) else $error("output not low while gated off");
    bypass_path_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (enable && gate && filter_code == 2'b00 && !invert)[*3] |-> cmp_out == $past(samp_q, 2))
        else $error("bypass path does not follow input");
    invert_path_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (enable && gate && invert)[*2] |-> cmp_out == !$past(filt_q))
        else $error("inverted output wrong");
    rise_irq_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rise_en && $rose(cmp_out)) |=> irq) else $error("rising edge lost");
    short_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (enable && filter_code == 2'b10 && $changed(samp_q) && samp_q != filt_q)
        ##1 (enable && samp_q != filt_q)[*2] ##1 $changed(samp_q) |-> $stable(filt_q))
        else $error("short pulse passed the filter");
endmodule : comparator_channel

// *** rtl/comparator_control.sv ***
// Comparator control registers and output paths for all channels
//
// Summary of operation
// - Three identical comparator channels, each with own control byte and output path.
// - Selected rising or falling output edges raise an interrupt request pulse.
// - Processed comparator outputs go to the timers.
// - Bits 6:5 set filter: off, or reject under 2, 4, 16 clocks.
// - Control registers reset to zero.
// - Registers take byte writes and single-bit set or clear.
// - Bit 7 enables the comparator and its input pins.
// - Bits 4:3 pick levels zero, one, two or common pin.
// - Bit 1 gates output; clear holds output low.
// - Bit 0 inverts output polarity.
// - Filter may reject one clock longer than programmed.
// - Level-select register bit 7 enables the reference generator for all.
`timescale 1ns/1ps
`include "comparator_control_defines.svh"
module comparator_control #(
    parameter int NUM_CH = 3
) (
    input  wire logic                sys_clk,
    input  wire logic                reset_n,
    input  wire logic [15:0]         cpu_addr,
    input  wire logic                cpu_wr_en,
    input  wire logic [7:0]          cpu_wr_data,
    input  wire logic                cpu_bit_set,
    input  wire logic                cpu_bit_clr,
    input  wire logic [2:0]          cpu_bit_sel,
    input  wire logic                cpu_rd_en,
    output logic      [7:0]          cpu_rd_data,
    input  wire logic [NUM_CH-1:0]   raw_result,
    input  wire logic [NUM_CH-1:0]   rising_edge_irq_enable,
    input  wire logic [NUM_CH-1:0]   falling_edge_irq_enable,
    output logic      [NUM_CH-1:0]   comparator_enable,
    output logic      [2*NUM_CH-1:0] reference_select,
    output logic      [NUM_CH-1:0]   comparator_out,
    output logic      [NUM_CH-1:0]   edge_irq,
    output logic                     reference_generator_enable,
    output logic      [4:0]          internal_level_zero_code
);
    // The address map only leaves room for three control bytes
    if (NUM_CH < 1 || NUM_CH > 3) begin : g_num_ch_check
        $error("NUM_CH must be 1 to 3");
    end

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    comparator_control_pkg::reg_byte_t ctl_q [NUM_CH];
    comparator_control_pkg::reg_byte_t lvl_q;
    comparator_control_pkg::reg_byte_t rd_q;
    logic [7:0]                        bit_mask;

    assign bit_mask = 8'h01 << cpu_bit_sel;

    // Byte write, or bit set/clear; bit 2 and other fixed bits stay zero
    function automatic logic [7:0] upd(input logic [7:0] cur, input logic [7:0] wmask);
        logic [7:0] nxt;
        nxt = cur;
        if (cpu_wr_en) begin
            nxt = cpu_wr_data;
        end else if (cpu_bit_set) begin
            nxt = cur | bit_mask;
        end else if (cpu_bit_clr) begin
            nxt = cur & ~bit_mask;
        end
        return nxt & wmask;
    endfunction : upd

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ctl
        localparam logic [15:0] ADDR = 16'(`CMP_CTL0_ADDR + i * `CMP_CTL_STRIDE);
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                ctl_q[i] <= `CMP_CTL_RESET;
            end else if (cpu_addr == ADDR) begin
                ctl_q[i] <= upd(ctl_q[i], `CMP_CTL_WMASK);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_q <= `CMP_LVL_RESET;
        end else if (cpu_addr == `CMP_LVL0_ADDR) begin
            lvl_q <= upd(lvl_q, `CMP_LVL_WMASK);
        end
    end

    // Read data is registered; unmapped addresses read zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q <= 8'h00;
        end else if (cpu_rd_en) begin
            rd_q <= 8'h00;
            if (cpu_addr == `CMP_LVL0_ADDR) begin
                rd_q <= lvl_q;
            end
            for (int k = 0; k < NUM_CH; k++) begin
                if (cpu_addr == 16'(`CMP_CTL0_ADDR + k * `CMP_CTL_STRIDE)) begin
                    rd_q <= ctl_q[k];
                end
            end
        end
    end
    assign cpu_rd_data = rd_q;

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        // Settings are applied directly; software keeps them still while enabled
        assign comparator_enable[i] = ctl_q[i][`CMP_BIT_ENABLE];
        assign reference_select[2*i +: 2] =
            ctl_q[i][`CMP_BIT_REF_HI:`CMP_BIT_REF_LO];

        comparator_channel u_ch (
            .sys_clk     (sys_clk),
            .rst_n       (rst_n),
            .raw_result  (raw_result[i]),
            .enable      (ctl_q[i][`CMP_BIT_ENABLE]),
            .filter_code (ctl_q[i][`CMP_BIT_FILT_HI:`CMP_BIT_FILT_LO]),
            .invert      (ctl_q[i][`CMP_BIT_INVERT]),
            .gate        (ctl_q[i][`CMP_BIT_GATE]),
            .rise_en     (rising_edge_irq_enable[i]),
            .fall_en     (falling_edge_irq_enable[i]),
            .cmp_out     (comparator_out[i]),
            .irq         (edge_irq[i])
        );
    end

    // Generator is shared; software turns it on before any channel
    assign reference_generator_enable = lvl_q[`CMP_BIT_REFGEN];
    assign internal_level_zero_code   = lvl_q[`CMP_LVL_HI:0];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    reset_zero_a: assert property (@(posedge sys_clk)
        $rose(rst_n) |-> ctl_q[0] == 8'h00 && comparator_out == '0)
        else $error("control not zero after reset");
    bit2_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ctl_q[0][2] == 1'b0) else $error("bit 2 not zero");
    byte_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cpu_wr_en && cpu_addr == 16'hFF62) |=> ctl_q[0] == ($past(cpu_wr_data) & 8'hFB))
        else $error("byte write not stored");
    bit_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!cpu_wr_en && cpu_bit_set && cpu_addr == 16'hFF62 && cpu_bit_sel == 3'h7)
        |=> comparator_enable[0] && $stable(ctl_q[0][6:0]))
        else $error("bit set failed");
    read_back_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cpu_rd_en && !cpu_wr_en && !cpu_bit_set && !cpu_bit_clr && cpu_addr == 16'hFF64)
        |=> cpu_rd_data == $past(ctl_q[1])) else $error("read data wrong");
    disabled_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !comparator_enable[0] [*2] |-> !comparator_out[0])
        else $error("disabled comparator drives output");
endmodule : comparator_control

// *** rtl/comparator_control_defines.svh ***
// Constants for the comparator control block
`ifndef COMPARATOR_CONTROL_DEFINES_SVH
`define COMPARATOR_CONTROL_DEFINES_SVH
`define CMP_CTL0_ADDR     16'hFF62
`define CMP_CTL_STRIDE    16'h0002
`define CMP_LVL0_ADDR     16'hFF68
`define CMP_CTL_RESET     8'h00
`define CMP_LVL_RESET     8'h00
`define CMP_CTL_WMASK     8'hFB
`define CMP_LVL_WMASK     8'h9F
`define CMP_BIT_ENABLE    7
`define CMP_BIT_FILT_HI   6
`define CMP_BIT_FILT_LO   5
`define CMP_BIT_REF_HI    4
`define CMP_BIT_REF_LO    3
`define CMP_BIT_GATE      1
`define CMP_BIT_INVERT    0
`define CMP_BIT_REFGEN    7
`define CMP_LVL_HI        4
`define CMP_FILT_CNT_W    4
`define CMP_FILT_LIM_01   4'h2
`define CMP_FILT_LIM_10   4'h4
`define CMP_FILT_LIM_11   5'h10
`endif

// *** rtl/comparator_control_pkg.sv ***
// Types shared by the comparator control block
package comparator_control_pkg;
    typedef enum logic [1:0] {
        FILT_OFF = 2'b00,
        FILT_W2  = 2'b01,
        FILT_W4  = 2'b10,
        FILT_W16 = 2'b11
    } filter_width_e;
    typedef enum logic [1:0] {
        REF_LEVEL_ZERO = 2'b00,
        REF_LEVEL_ONE  = 2'b01,
        REF_LEVEL_TWO  = 2'b10,
        REF_COMMON_PIN = 2'b11
    } reference_select_e;
    typedef logic [7:0] reg_byte_t;
endpackage : comparator_control_pkg

// *** tb/analog_source.sv ***
// Stand-in for the analog comparators and the edge-enable levels
`timescale 1ns/1ps
module analog_source (
    input  wire logic       sys_clk,
    output logic      [2:0] raw_result,
    output logic      [2:0] rising_edge_irq_enable,
    output logic      [2:0] falling_edge_irq_enable
);
    initial begin
        raw_result = 3'h0;
        rising_edge_irq_enable = 3'h0;
        falling_edge_irq_enable = 3'h0;
    end
    // High for len clocks; widths picked against filter width plus one
    task automatic pulse(input int ch, input int len);
        @(posedge sys_clk);
        raw_result[ch] <= 1'b1;
        repeat (len) @(posedge sys_clk);
        raw_result[ch] <= 1'b0;
    endtask : pulse
    task automatic edges(input logic [2:0] rise, input logic [2:0] fall);
        @(posedge sys_clk);
        rising_edge_irq_enable  <= rise;
        falling_edge_irq_enable <= fall;
    endtask : edges
endmodule : analog_source

// *** tb/comparator_control_test.sv ***
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
module comparator_control_test;
    logic        sys_clk, reset_n, cpu_wr_en, cpu_bit_set, cpu_bit_clr, cpu_rd_en;
    logic [15:0] cpu_addr;
    logic [7:0]  cpu_wr_data, cpu_rd_data;
    logic [2:0]  cpu_bit_sel, raw_result, rise_en, fall_en;
    logic [2:0]  comparator_enable, comparator_out, edge_irq;
    logic [5:0]  reference_select;
    logic        reference_generator_enable;
    logic [4:0]  internal_level_zero_code;
    int          mismatches, comparisons, irq_cnt;

    comparator_control #(.NUM_CH(3)) i_comparator_control (.sys_clk(sys_clk),
        .reset_n(reset_n), .cpu_addr(cpu_addr), .cpu_wr_en(cpu_wr_en),
        .cpu_wr_data(cpu_wr_data), .cpu_bit_set(cpu_bit_set), .cpu_bit_clr(cpu_bit_clr),
        .cpu_bit_sel(cpu_bit_sel), .cpu_rd_en(cpu_rd_en), .cpu_rd_data(cpu_rd_data),
        .raw_result(raw_result), .rising_edge_irq_enable(rise_en),
        .falling_edge_irq_enable(fall_en), .comparator_enable(comparator_enable),
        .reference_select(reference_select), .comparator_out(comparator_out),
        .edge_irq(edge_irq), .reference_generator_enable(reference_generator_enable),
        .internal_level_zero_code(internal_level_zero_code));
    analog_source i_analog_source (.sys_clk(sys_clk), .raw_result(raw_result),
        .rising_edge_irq_enable(rise_en), .falling_edge_irq_enable(fall_en));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        irq_cnt <= irq_cnt + $countones(edge_irq);
    end

    // ---------------------------------------------------------------
    // Shared helpers
    // ---------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // op 0 byte write, 1 bit set, 2 bit clear, 3 read; d[2:0] is the bit index
    task automatic bus(input int op, input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        cpu_addr    <= a;
        cpu_wr_data <= d;
        cpu_bit_sel <= d[2:0];
        cpu_wr_en   <= (op == 0);
        cpu_bit_set <= (op == 1);
        cpu_bit_clr <= (op == 2);
        cpu_rd_en   <= (op == 3);
        @(posedge sys_clk);
        {cpu_wr_en, cpu_bit_set, cpu_bit_clr, cpu_rd_en} <= 4'h0;
        #1;
    endtask : bus
    // Settings change only while stopped; generator on, then enable goes last
    task automatic cfg(input int ch, input logic [7:0] v);
        bus(2, 16'hFF62 + 16'(2 * ch), 8'h07);
        bus(0, 16'hFF62 + 16'(2 * ch), v & 8'h7F);
        bus(1, 16'hFF68, 8'h07);
        bus(1, 16'hFF62 + 16'(2 * ch), 8'h07);
        repeat (30) @(posedge sys_clk);
    endtask : cfg
    task automatic pulse_case(input int ch, input logic [7:0] ctl, input int len, input int n);
        int i0;
        cfg(ch, ctl);
        i0 = irq_cnt;
        i_analog_source.pulse(ch, len);
        repeat (40) @(posedge sys_clk);
        chk(8'(irq_cnt - i0), 8'(n));
    endtask : pulse_case

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        for (int a = 0; a < 4; a++) begin
            bus(3, 16'hFF62 + 16'(2 * a), 8'h00);
            chk(cpu_rd_data, 8'h00);
        end
        chk({2'h0, comparator_enable, comparator_out}, 8'h00);
        $display("done: reset");
    endtask : t_reset
    task automatic t_regs();
        for (int ch = 0; ch < 3; ch++) begin
            bus(0, 16'hFF62 + 16'(2 * ch), 8'h7F);
            bus(3, 16'hFF62 + 16'(2 * ch), 8'h00);
            chk(cpu_rd_data, 8'h7B);
            chk({6'h0, reference_select[2*ch +: 2]}, 8'h03);
            bus(1, 16'hFF62 + 16'(2 * ch), 8'h07);
            chk({5'h0, comparator_enable}, 8'(1 << ch));
            bus(3, 16'hFF62 + 16'(2 * ch), 8'h00);
            chk(cpu_rd_data, 8'hFB);
            bus(2, 16'hFF62 + 16'(2 * ch), 8'h07);
            bus(0, 16'hFF62 + 16'(2 * ch), 8'h00);
            bus(1, 16'hFF62 + 16'(2 * ch), 8'h02);
            bus(3, 16'hFF62 + 16'(2 * ch), 8'h00);
            chk(cpu_rd_data, 8'h00);
        end
        bus(0, 16'hFF6A, 8'h55);
        bus(3, 16'hFF6A, 8'h00);
        chk(cpu_rd_data, 8'h00);
        bus(0, 16'hFF68, 8'hFF);
        bus(3, 16'hFF68, 8'h00);
        chk(cpu_rd_data, 8'h9F);
        chk({2'h0, reference_generator_enable, internal_level_zero_code}, 8'h3F);
        $display("done: registers");
    endtask : t_regs
    task automatic t_ref();
        for (int c = 0; c < 4; c++) begin
            bus(0, 16'hFF66, 8'(c << 3));
            chk({6'h0, reference_select[5:4]}, 8'(c));
        end
        $display("done: reference");
    endtask : t_ref
    task automatic t_filter();
        int w [4] = '{1, 2, 4, 16};
        i_analog_source.edges(3'h7, 3'h0);
        for (int c = 0; c < 4; c++) begin
            if (c > 0) pulse_case(c % 3, 8'(c << 5) | 8'h02, w[c] - 1, 0);
            pulse_case(c % 3, 8'(c << 5) | 8'h02, w[c] + 2, 1);
        end
        $display("done: filter");
    endtask : t_filter
    task automatic t_polarity();
        i_analog_source.edges(3'h0, 3'h2);
        cfg(1, 8'h01);
        chk({7'h0, comparator_out[1]}, 8'h00);
        pulse_case(1, 8'h03, 4, 1);
        chk({7'h0, comparator_out[1]}, 8'h01);
        bus(2, 16'hFF64, 8'h07);
        repeat (10) @(posedge sys_clk);
        chk({7'h0, comparator_out[1]}, 8'h00);
        $display("done: polarity");
    endtask : t_polarity

    task automatic tally_and_finish();
        $display("Counts: comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #200000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        reset_n = 1'b0;
        {cpu_wr_en, cpu_bit_set, cpu_bit_clr, cpu_rd_en} = 4'h0;
        cpu_addr = 16'h0000;
        cpu_wr_data = 8'h00;
        cpu_bit_sel = 3'h0;
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_reset();
        t_regs();
        t_ref();
        t_filter();
        t_polarity();
        tally_and_finish();
    end
endmodule : comparator_control_test
